//--- core/touch_sampling_control.sv
// touch sampling controller with ahb-lite register slave
`timescale 1ns/10ps
module touch_sampling_control #(
  parameter int unsigned RATE_CYCLES = touch_pkg::RATE_CYCLES_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // display timing
  input wire logic frame_start,
  // panel and converter
  input wire logic adc_done,
  output logic panel_charge,
  output logic adc_start,
  output logic adc_diff
);
  localparam int CW = touch_pkg::CNT_W;

  // elaboration check: the period counter must be able to hold the rate
  if (RATE_CYCLES < 1 || RATE_CYCLES >= (1 << CW)) begin : g_rate_check
    $error("RATE_CYCLES out of range");
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [1:0] sched_reg, sched_next;
  logic conv_reg, conv_next;
  logic [15:0] charge_reg, charge_next;
  logic [3:0] settle_reg, settle_next;
  logic single_reg, single_next;
  logic frame_reg, frame_next;
  touch_pkg::bus_cap_s cap_reg, cap_next;
  logic [31:0] hrdata_next;
  logic [15:0] samples_reg, samples_next;
  logic start;
  logic [CW-1:0] charge_cycles, settle_cycles;
  // sequencer state, declared here because the status read looks at it
  touch_pkg::phase_e phase_reg, phase_next;

  // address phase capture and register writes in the data phase
  always_comb begin
    logic take;
    take = hsel && htrans[touch_pkg::HTRANS_ACT] && hready;
    cap_next.wr = take && hwrite;
    cap_next.addr = haddr;
    sched_next = sched_reg;
    conv_next = conv_reg;
    charge_next = charge_reg;
    settle_next = settle_reg;
    single_next = single_reg && !start;
    // at most one frame waits; the pulse that starts a sample is used up by it
    frame_next = (sched_reg == touch_pkg::SCHED_FRAME)
                 && ((frame_reg && frame_start) || ((frame_reg || frame_start) && !start));
    if (cap_reg.wr) begin
      unique case (cap_reg.addr)
        touch_pkg::ADDR_SCHED: begin
          sched_next = hwdata[1:0];
          single_next = single_next || (hwdata[1:0] == touch_pkg::SCHED_SINGLE);
        end
        touch_pkg::ADDR_CONV: conv_next = hwdata[0];
        touch_pkg::ADDR_CHARGE: charge_next = hwdata[15:0];
        touch_pkg::ADDR_SETTLE: settle_next = hwdata[3:0];
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // read mux looks at next values so a write then read back to back is seen
  always_comb begin
    hrdata_next = 32'h00000000;
    if (hsel && htrans[touch_pkg::HTRANS_ACT] && hready && !hwrite) begin
      unique case (haddr)
        touch_pkg::ADDR_SCHED: hrdata_next[1:0] = sched_next;
        touch_pkg::ADDR_CONV: hrdata_next[0] = conv_next;
        touch_pkg::ADDR_CHARGE: hrdata_next[15:0] = charge_next;
        touch_pkg::ADDR_SETTLE: hrdata_next[3:0] = settle_next;
        touch_pkg::ADDR_STATUS: begin
          hrdata_next[15:0] = samples_next;
          hrdata_next[touch_pkg::STAT_PHASE_LSB +: 5] = phase_next;
        end
        default: ; // unmapped reads give zero
      endcase
    end
  end

  // register file and bus outputs; reset loads the defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sched_reg <= touch_pkg::SCHED_RST;
      conv_reg <= touch_pkg::CONV_RST;
      charge_reg <= touch_pkg::CHARGE_RST;
      settle_reg <= touch_pkg::SETTLE_RST;
      single_reg <= 1'h0;
      frame_reg <= 1'h0;
      cap_reg <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      sched_reg <= sched_next;
      conv_reg <= conv_next;
      charge_reg <= charge_next;
      settle_reg <= settle_next;
      single_reg <= single_next;
      frame_reg <= frame_next;
      cap_reg <= cap_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'h1; // zero wait states, always okay
      hresp <= 1'h0;
    end
  end

  // phase lengths in clocks, six clocks per unit
  // widen before multiplying: the largest charge setting needs 19 bits
  assign charge_cycles = CW'(charge_reg) * CW'(touch_pkg::TICK_CLOCKS);
  assign settle_cycles = CW'(settle_reg) * CW'(touch_pkg::TICK_CLOCKS);

  logic [CW-1:0] cnt_reg, cnt_next;
  logic [CW-1:0] rate_reg, rate_next;
  logic go;

  // pick the trigger for the schedule now in force
  always_comb begin
    unique case (sched_reg)
      touch_pkg::SCHED_OFF: go = 1'h0;
      touch_pkg::SCHED_SINGLE: go = single_reg;
      touch_pkg::SCHED_FRAME: go = frame_reg || frame_start;
      touch_pkg::SCHED_CONT: go = (rate_reg == '0);
    endcase
  end

  // sampling sequencer; a zero setting still gives one cycle
  always_comb begin
    phase_next = phase_reg;
    cnt_next = (cnt_reg > 1) ? CW'(cnt_reg - 1'b1) : cnt_reg;
    rate_next = (rate_reg != '0) ? CW'(rate_reg - 1'b1) : rate_reg;
    samples_next = samples_reg;
    start = 1'h0;
    unique case (phase_reg)
      touch_pkg::PH_IDLE, touch_pkg::PH_HOLD: begin
        if (go) begin
          phase_next = touch_pkg::PH_CHARGE;
          cnt_next = charge_cycles;
          rate_next = CW'(RATE_CYCLES - 1);
          start = 1'h1;
        end
      end
      touch_pkg::PH_CHARGE: begin
        if (cnt_reg <= 1) begin
          phase_next = touch_pkg::PH_SETTLE;
          cnt_next = settle_cycles;
        end
      end
      touch_pkg::PH_SETTLE: begin
        if (cnt_reg <= 1) begin
          phase_next = touch_pkg::PH_CONVERT;
        end
      end
      touch_pkg::PH_CONVERT: begin
        if (adc_done) begin
          samples_next = samples_reg + 16'h0001;
          // continuous waits out the rest of the period; others go idle
          phase_next = (sched_reg == touch_pkg::SCHED_CONT) ? touch_pkg::PH_HOLD
                                                             : touch_pkg::PH_IDLE;
        end
      end
    endcase
    // turning sampling off aborts a sample in progress
    if (sched_reg == touch_pkg::SCHED_OFF) begin
      phase_next = touch_pkg::PH_IDLE;
      start = 1'h0;
    end
  end

  logic charge_next_o, adc_start_next;

  // panel outputs registered so they come straight from flops
  always_comb begin
    charge_next_o = (phase_next == touch_pkg::PH_CHARGE);
    adc_start_next = (phase_reg == touch_pkg::PH_SETTLE)
                     && (phase_next == touch_pkg::PH_CONVERT);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= touch_pkg::PH_IDLE;
      cnt_reg <= '0;
      rate_reg <= '0;
      samples_reg <= 16'h0000;
      panel_charge <= 1'h0;
      adc_start <= 1'h0;
      adc_diff <= touch_pkg::CONV_RST;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      rate_reg <= rate_next;
      samples_reg <= samples_next;
      panel_charge <= charge_next_o;
      adc_start <= adc_start_next;
      adc_diff <= conv_reg;
    end
  end

  // helper flags for the checks below
  logic first_reg;
  logic [CW-1:0] gap_reg;
  logic [1:0] shots_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_reg <= 1'h1;
      gap_reg <= '0;
      shots_reg <= 2'h0;
    end else begin
      first_reg <= 1'h0;
      gap_reg <= start ? '0 : ((gap_reg != '1) ? CW'(gap_reg + 1'b1) : gap_reg);
      if (cap_reg.wr && cap_reg.addr == touch_pkg::ADDR_SCHED) begin
        shots_reg <= 2'h0;
      end else if (start && shots_reg != 2'h3) begin
        shots_reg <= shots_reg + 2'h1;
      end
    end
  end

  // named steps of a sample, shared by the checks below
  sequence s_enter_charge;
    phase_reg != touch_pkg::PH_CHARGE ##1 phase_reg == touch_pkg::PH_CHARGE;
  endsequence

  sequence s_enter_settle;
    phase_reg == touch_pkg::PH_CHARGE ##1 phase_reg == touch_pkg::PH_SETTLE;
  endsequence

  sequence s_enter_convert;
    phase_reg == touch_pkg::PH_SETTLE ##1 phase_reg == touch_pkg::PH_CONVERT;
  endsequence

  // a write of the one-shot code while sampling is off
  sequence s_single_write;
    cap_reg.wr && cap_reg.addr == touch_pkg::ADDR_SCHED && sched_reg == touch_pkg::SCHED_OFF
      && hwdata[1:0] == touch_pkg::SCHED_SINGLE;
  endsequence

  a_charge_load: assert property (s_enter_charge |-> cnt_reg == charge_cycles)
    else $error("charge count not loaded from setting");
  a_charge_end: assert property (phase_reg == touch_pkg::PH_CHARGE && cnt_reg == 6
      && sched_reg != touch_pkg::SCHED_OFF |-> panel_charge [*6] ##1 phase_reg
      == touch_pkg::PH_SETTLE)
    else $error("charge phase ended at wrong time");
  a_settle_load: assert property (s_enter_settle |-> cnt_reg == settle_cycles)
    else $error("settle count not loaded from setting");
  a_settle_len: assert property (phase_reg == touch_pkg::PH_SETTLE && cnt_reg == 6
      && sched_reg != touch_pkg::SCHED_OFF |-> (phase_reg == touch_pkg::PH_SETTLE) [*6]
      ##1 phase_reg == touch_pkg::PH_CONVERT)
    else $error("settle phase ended at wrong time");
  a_adc_pulse: assert property (s_enter_convert |-> adc_start ##1 !adc_start)
    else $error("conversion start is not a single pulse");
  a_reset_values: assert property (first_reg |-> sched_reg == 2'h3 && conv_reg
      && charge_reg == 16'h1770 && settle_reg == 4'h3)
    else $error("register defaults wrong after reset");
  a_adc_mode: assert property ($rose(adc_start) |-> adc_diff == $past(conv_reg))
    else $error("converter mode does not follow setting");

  // schedule checks
  a_off_idle: assert property (sched_reg == touch_pkg::SCHED_OFF |=> phase_reg
      == touch_pkg::PH_IDLE && !panel_charge)
    else $error("sampling active while off");
  a_single_once: assert property (sched_reg == touch_pkg::SCHED_SINGLE
      |-> shots_reg <= 2'h1)
    else $error("single mode sampled more than once");
  a_single_arm: assert property (s_single_write |-> ##2 panel_charge)
    else $error("one-shot write did not start a sample");
  a_frame_go: assert property (phase_reg == touch_pkg::PH_IDLE && frame_start
      && sched_reg == touch_pkg::SCHED_FRAME |=> phase_reg == touch_pkg::PH_CHARGE
      ##1 panel_charge)
    else $error("frame start did not begin a sample");
  a_rate_gap: assert property (start && sched_reg == touch_pkg::SCHED_CONT
      && !first_reg && $past(sched_reg) == touch_pkg::SCHED_CONT
      |-> gap_reg >= CW'(RATE_CYCLES - 1))
    else $error("continuous samples too close together");
  a_cont_hold: assert property (phase_reg == touch_pkg::PH_CONVERT && adc_done
      && sched_reg == touch_pkg::SCHED_CONT |=> phase_reg == touch_pkg::PH_HOLD)
    else $error("continuous sample did not wait out the period");
  a_hold_wait: assert property (phase_reg == touch_pkg::PH_HOLD && rate_reg != '0
      && sched_reg == touch_pkg::SCHED_CONT |=> !panel_charge)
    else $error("continuous sample started before the period ran out");

  // bus checks
  a_reserved_zero: assert property (hsel && htrans[1] && hready && !hwrite
      && haddr == touch_pkg::ADDR_SCHED |=> hrdata[31:2] == 30'h00000000)
    else $error("reserved bits read nonzero");
endmodule

//--- dv/test_touch_sampling_control.sv
// testbench for the touch sampling controller
`timescale 1ns/10ps
module test_touch_sampling_control;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic frame_start = 1'b0;
  logic slow = 1'b0;
  logic adc_done, panel_charge, adc_start, adc_diff;
  logic [31:0] rd_val;
  int errors = 0;
  int cmp_count = 0;
  int starts = 0;
  int run = 0;
  int plen = 0;
  int s0;

  // small rate keeps continuous mode short in simulation
  touch_sampling_control #(.RATE_CYCLES(200)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start),
    .adc_done(adc_done), .panel_charge(panel_charge), .adc_start(adc_start),
    .adc_diff(adc_diff));

  touch_adc_model adc_u (.hclk(hclk), .hresetn(hresetn), .adc_start(adc_start),
    .slow(slow), .adc_done(adc_done));

  always #2 hclk = ~hclk;

  // count conversions and measure the last charge pulse
  always @(posedge hclk) begin
    if (adc_start === 1'b1) starts <= starts + 1;
    if (panel_charge === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      plen <= run;
      run <= 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one ahb-lite single transfer; waits on hready in both phases
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_val = hrdata;
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd_val);
  endtask

  task automatic pulse_frame();
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    repeat (200) @(posedge hclk);
  endtask

  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("sched", touch_pkg::ADDR_SCHED, 32'h3);
    rd_chk("conv", touch_pkg::ADDR_CONV, 32'h1);
    rd_chk("charge", touch_pkg::ADDR_CHARGE, 32'h1770);
    rd_chk("settle", touch_pkg::ADDR_SETTLE, 32'h3);
    chk("diff", 32'h1, {31'h0, adc_diff});
    xfer(1'b1, touch_pkg::ADDR_SCHED, 32'h0);
    xfer(1'b1, touch_pkg::ADDR_CHARGE, 32'hffff0002);
    rd_chk("charge", touch_pkg::ADDR_CHARGE, 32'h2);
    xfer(1'b1, touch_pkg::ADDR_SETTLE, 32'h1);
    xfer(1'b1, touch_pkg::ADDR_CONV, 32'h0);
    rd_chk("conv", touch_pkg::ADDR_CONV, 32'h0);
    chk("diff", 32'h0, {31'h0, adc_diff});
    rd_chk("unmapped", 32'h001024e0, 32'h0);
    chk("resp", 32'h0, {31'h0, hresp});
    // off: nothing may start
    s0 = starts;
    repeat (300) @(posedge hclk);
    chk("off", 32'h0, starts - s0);
    // single shot; reserved bits set in the write must read back clear
    xfer(1'b1, touch_pkg::ADDR_SCHED, 32'hfffffffd);
    rd_chk("sched", touch_pkg::ADDR_SCHED, 32'h1);
    repeat (300) @(posedge hclk);
    chk("single", 32'h1, starts - s0);
    chk("charge_len", 32'hc, plen);
    // one completed sample, sequencer back to idle
    rd_chk("status", touch_pkg::ADDR_STATUS, 32'h00010001);
    // frame mode with a slow converter
    slow <= 1'b1;
    xfer(1'b1, touch_pkg::ADDR_SCHED, 32'h2);
    s0 = starts;
    repeat (100) @(posedge hclk);
    chk("no_frame", 32'h0, starts - s0);
    pulse_frame();
    pulse_frame();
    chk("frame", 32'h2, starts - s0);
    // continuous, bounded by the rate period
    slow <= 1'b0;
    xfer(1'b1, touch_pkg::ADDR_CONV, 32'h1);
    rd_chk("conv", touch_pkg::ADDR_CONV, 32'h1);
    chk("diff", 32'h1, {31'h0, adc_diff});
    xfer(1'b1, touch_pkg::ADDR_SCHED, 32'h3);
    s0 = starts;
    repeat (1000) @(posedge hclk);
    chk("rate", 32'h1, {31'h0, (starts - s0 >= 4) && (starts - s0 <= 6)});
    // reset in mid-run brings the defaults back
    xfer(1'b1, touch_pkg::ADDR_CHARGE, 32'h5);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("charge", touch_pkg::ADDR_CHARGE, 32'h1770);
    rd_chk("sched", touch_pkg::ADDR_SCHED, 32'h3);
    end_of_test();
  end
endmodule

//--- dv/touch_adc_model.sv
// converter model that answers each conversion start with a done pulse
`timescale 1ns/10ps
module touch_adc_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // converter handshake
  input wire logic adc_start,
  input wire logic slow,
  output logic adc_done
);
  int unsigned wait_cnt;
  // one done pulse per start; slow mode stretches the conversion
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 0;
      adc_done <= 1'b0;
    end else begin
      adc_done <= (wait_cnt == 1);
      if (adc_start) begin
        wait_cnt <= slow ? 40 : 3;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

//--- shared/touch_pkg.sv
// constants and types for the touch sampling control block
// Behaviour
// - charge panel for setting times six clocks
// - charge setting resets to 6000
// - mode bit 0 samples single-ended
// - mode bit 1 samples differential, reset value
// - schedule 00 takes no samples
// - schedule 01 takes exactly one sample
// - schedule 10 samples at each frame start
// - schedule 11 repeats, at most 1000/s
// - schedule resets to continuous
// - settle for setting times six, reset 3
package touch_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_SETTLE = 32'h001024ec;
  localparam logic [31:0] ADDR_SCHED = 32'h001024f0;
  localparam logic [31:0] ADDR_CONV = 32'h001024f4;
  localparam logic [31:0] ADDR_CHARGE = 32'h001024f8;
  localparam logic [31:0] ADDR_STATUS = 32'h001024fc;
  // field widths
  localparam int SCHED_W = 2;
  localparam int CHARGE_W = 16;
  localparam int SETTLE_W = 4;
  localparam int CNT_W = 20;
  localparam int SAMPLES_W = 16;
  // status field positions
  localparam int STAT_PHASE_LSB = 16;
  // reset values
  localparam logic [1:0] SCHED_RST = 2'h3;
  localparam logic CONV_RST = 1'h1;
  localparam logic [15:0] CHARGE_RST = 16'h1770;
  localparam logic [3:0] SETTLE_RST = 4'h3;
  // schedule encodings
  localparam logic [1:0] SCHED_OFF = 2'h0;
  localparam logic [1:0] SCHED_SINGLE = 2'h1;
  localparam logic [1:0] SCHED_FRAME = 2'h2;
  localparam logic [1:0] SCHED_CONT = 2'h3;
  // timing
  localparam logic [2:0] TICK_CLOCKS = 3'h6;
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int RATE_CYCLES_DEF = SAMPLE_PERIOD_US * CLK_MHZ;
  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACT = 1;
  // sampling phases, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_CHARGE = 5'h02,
    PH_SETTLE = 5'h04,
    PH_CONVERT = 5'h08,
    PH_HOLD = 5'h10
  } phase_e;
  // captured address phase
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
  } bus_cap_s;
endpackage
